/* sah_adc_ctrl.sv */
// Control and host interface of a 10-bit successive-approximation converter.
// Notes on behaviour
// - Mode pin high picks the parallel bus, low picks the serial interface.
// - Conversion done output goes low when a finished result is ready.
// - Parallel write with select low latches data bits 2..0 as channel.
// - Parallel write with select high is an initialize write, allowed any time.
// - Initialize bit 2 high gives two's complement, low gives straight binary.
// - Initialize bits 1..0 pick divide ratio 1/1, 1/2, 1/4 or 1/8.
// - Read with select high puts the eight upper result bits on the bus.
// - Read with select low puts bit one and LSB on top, zeros below.
// - Ten-bit result by successive approximation, same for every interface.
// - Each step compares input against a DAC level set by the SAR.
// - Serial output is three-state and changes on the active clock falling edge.
// - Serial input is sampled on the active shift clock rising edge.
// - Order select high shifts LSB first, low shifts MSB first.
// - Serial select low is mode 1 host clock; high is mode 2 device clock.
// - Mode 2 serial clock output copies the internal divided clock.
// - Mode 2 serial clock period equals one internal clock period.
// - Mode 2 output valid goes low while result bits are shifted out.
// - Mode 1 latches the channel at the strobe rising edge.
// - Mode 2 chip select low holds the sequence reset; rising edge starts.
// - Mode 1 chip select high ignores serial inputs and floats serial output.
// - Mode 2 initialization selects analog channel 7.
`timescale 1ns/1ps
`include "sah_defs.svh"

module sah_adc_ctrl
  import sah_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host control pins
  input wire logic interface_mode_pin,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic register_select,
  input wire logic ext_clock,
  // Shared data bus and serial pins
  input wire logic [`SAH_DB_W-1:0] data_bus_in,
  output logic [`SAH_DB_W-1:0] data_bus_out,
  output logic [`SAH_DB_W-1:0] data_bus_oe,
  // Status
  output logic conversion_done_n,
  // Analog front end
  output logic [`SAH_CH_W-1:0] analog_input_mux,
  output logic [`SAH_RES_W-1:0] dac_level,
  input wire logic comparator_high
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [`SAH_SYNC_W-1:0] raw_in;
  logic [`SAH_SYNC_W-1:0] sync1;
  logic [`SAH_SYNC_W-1:0] sync2;
  logic [`SAH_SYNC_W-1:0] prev;

  assign raw_in = {data_bus_in, comparator_high, ext_clock, interface_mode_pin,
                   register_select, read_strobe_n, write_strobe_n, chip_select_n};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1 <= `SAH_SYNC_IDLE;
      sync2 <= `SAH_SYNC_IDLE;
      prev <= `SAH_SYNC_IDLE;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  logic [`SAH_DB_W-1:0] db_now;
  logic [`SAH_DB_W-1:0] db_prev;
  logic cs_low;
  logic mode_par;
  logic mode1;
  logic mode2;
  logic wr_rise;
  logic rd_rise;
  logic rd_fall;
  logic cs_rise;
  logic cs_fall;
  logic par_wr;
  logic addr_wr;
  logic init_wr;
  logic par_rd;
  logic low_read_done;

  assign db_now = sync2[`SAH_S_DB +: `SAH_DB_W];
  assign db_prev = prev[`SAH_S_DB +: `SAH_DB_W];
  assign cs_low = !sync2[`SAH_S_CS];
  assign mode_par = sync2[`SAH_S_MC];
  assign mode1 = !mode_par && !sync2[`SAH_S_RS];
  assign mode2 = !mode_par && sync2[`SAH_S_RS];
  assign wr_rise = sync2[`SAH_S_WR] && !prev[`SAH_S_WR];
  assign rd_rise = sync2[`SAH_S_RD] && !prev[`SAH_S_RD];
  assign rd_fall = !sync2[`SAH_S_RD] && prev[`SAH_S_RD];
  assign cs_rise = sync2[`SAH_S_CS] && !prev[`SAH_S_CS];
  assign cs_fall = !sync2[`SAH_S_CS] && prev[`SAH_S_CS];

  // Writes are taken at the trailing edge of the strobe, with the bus value seen just before it.
  assign par_wr = mode_par && wr_rise && !prev[`SAH_S_CS] && prev[`SAH_S_RD];
  assign addr_wr = par_wr && !prev[`SAH_S_RS];
  assign init_wr = par_wr && prev[`SAH_S_RS];
  assign par_rd = mode_par && cs_low && !sync2[`SAH_S_RD] && sync2[`SAH_S_WR];
  assign low_read_done = mode_par && rd_rise && !prev[`SAH_S_CS] && prev[`SAH_S_WR] && !prev[`SAH_S_RS];

  // ************************************************************
  // Configuration
  // ************************************************************
  logic fmt_cfg;
  logic [1:0] div_cfg;
  logic fmt_eff;
  logic [1:0] div_eff;
  logic [`SAH_CH_W-1:0] chan;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fmt_cfg <= 1'b0;
      div_cfg <= `SAH_DIV_RESET;
    end else if (init_wr) begin
      fmt_cfg <= db_prev[`SAH_FMT_BIT];
      div_cfg <= {db_prev[`SAH_DIV_HI], db_prev[`SAH_DIV_LO]};
    end
  end

  // Serial hosts steer format and ratio on the shared bus pins as static levels.
  assign fmt_eff = mode_par ? fmt_cfg : db_now[`SAH_FMT_BIT];
  assign div_eff = mode_par ? div_cfg : {db_now[`SAH_DIV_HI], db_now[`SAH_DIV_LO]};

  // ************************************************************
  // Internal clock divider
  // ************************************************************
  function automatic logic [2:0] sah_div_last(input logic [1:0] code);
    case (code)
      2'h0: sah_div_last = 3'h0;
      2'h1: sah_div_last = 3'h1;
      2'h2: sah_div_last = 3'h3;
      default: sah_div_last = 3'h7;
    endcase
  endfunction : sah_div_last

  logic [2:0] div_cnt;
  logic int_clk;
  logic int_toggle;
  logic int_rise;
  logic int_fall;

  // Every edge of the external clock is a half period; ratio n toggles after n edges.
  assign int_toggle = (sync2[`SAH_S_CK] != prev[`SAH_S_CK]) && (div_cnt == sah_div_last(div_eff));
  assign int_rise = int_toggle && !int_clk;
  assign int_fall = int_toggle && int_clk;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt <= `SAH_DIV_CNT_ZERO;
    end else if (sync2[`SAH_S_CK] != prev[`SAH_S_CK]) begin
      div_cnt <= int_toggle ? `SAH_DIV_CNT_ZERO : div_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_clk <= 1'b0;
    end else if (int_toggle) begin
      int_clk <= !int_clk;
    end
  end

  // ************************************************************
  // Successive approximation sequencer
  // ************************************************************
  sah_conv_e conv_state;
  sah_word_t sar;
  logic [3:0] bit_idx;
  logic seq_clear;
  logic start;
  logic fifo_in_ready;
  logic [`SAH_CH_W-1:0] si_shift;
  logic settled;

  // A parallel chip select falling edge, or a low chip select in mode 2, clears the sequence.
  assign seq_clear = (mode_par && cs_fall) || (mode2 && cs_low);
  assign start = addr_wr || (mode1 && cs_low && wr_rise) || (mode2 && cs_rise);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chan <= `SAH_CH_INIT;
    end else if (mode2 && cs_low) begin
      chan <= `SAH_CH_SP;
    end else if (addr_wr) begin
      chan <= db_prev[`SAH_CH_W-1:0];
    end else if (mode1 && cs_low && wr_rise) begin
      chan <= si_shift;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv_state <= SAH_IDLE;
      sar <= `SAH_SAR_CLEAR;
      bit_idx <= `SAH_LAST_BIT;
    end else if (seq_clear) begin
      conv_state <= SAH_IDLE;
    end else begin
      case (conv_state)
        SAH_IDLE: begin
          if (start) begin
            conv_state <= SAH_RUN;
            sar <= `SAH_SAR_START;
            bit_idx <= `SAH_LAST_BIT;
          end
        end
        SAH_RUN: begin
          if (int_rise && settled) begin
            // The DAC has settled on the trial code for a whole internal period, or at least half of one on the first step.
            if (!sync2[`SAH_S_CMP]) begin
              sar[bit_idx] <= 1'b0;
            end
            if (bit_idx == `SAH_BIT_ZERO) begin
              conv_state <= SAH_PUSH;
            end else begin
              sar[bit_idx - 4'h1] <= 1'b1;
              bit_idx <= bit_idx - 4'h1;
            end
          end
        end
        SAH_PUSH: begin
          // A full result queue stalls the sequencer here rather than losing a word.
          if (fifo_in_ready) begin
            conv_state <= SAH_IDLE;
          end
        end
        default: conv_state <= SAH_IDLE;
      endcase
    end
  end

  // The comparator is seen through two flip-flops, so a rise right after a start would judge a stale level.
  // The first decision therefore waits for a falling internal clock edge after the start.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settled <= 1'b0;
    end else if (conv_state != SAH_RUN) begin
      settled <= 1'b0;
    end else if (int_fall) begin
      settled <= 1'b1;
    end
  end

  assign dac_level = sar;
  assign analog_input_mux = chan;

  // ************************************************************
  // Result queue and output word
  // ************************************************************
  sah_word_t fmt_word;
  sah_word_t fifo_word;
  sah_word_t out_word;
  logic fifo_out_valid;
  logic out_valid;
  logic consume;

  // Two's complement of an offset-binary code is the code with its top bit inverted.
  assign fmt_word = fmt_eff ? {!sar[`SAH_RES_W-1], sar[`SAH_RES_W-2:0]} : sar;

  sah_fifo #(
    .WIDTH(`SAH_RES_W),
    .DEPTH(`SAH_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(conv_state == SAH_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(fmt_word),
    .out_valid(fifo_out_valid),
    .out_ready(!out_valid),
    .out_data(fifo_word)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_word <= `SAH_SAR_CLEAR;
    end else if (!out_valid && fifo_out_valid) begin
      out_valid <= 1'b1;
      out_word <= fifo_word;
    end else if (consume) begin
      out_valid <= 1'b0;
    end
  end

  assign conversion_done_n = !out_valid;

  // ************************************************************
  // Serial shifter
  // ************************************************************
  logic shift_rise;
  logic shift_fall;
  logic lsb_first;
  logic sh_busy;
  logic [3:0] sh_cnt;
  sah_word_t sh_reg;
  logic so_bit;
  logic sh_done;

  // Mode 1 uses the host clock only while selected; mode 2 uses the internal clock.
  assign shift_rise = (mode1 && cs_low && rd_rise) || (mode2 && int_rise);
  assign shift_fall = (mode1 && cs_low && rd_fall) || (mode2 && int_fall);
  assign lsb_first = db_now[`SAH_ORDER_BIT];
  assign sh_done = shift_fall && sh_busy && (sh_cnt == `SAH_SHIFT_LEN);
  assign consume = low_read_done || sh_done;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      si_shift <= `SAH_CH_INIT;
    end else if (mode1 && shift_rise) begin
      si_shift <= {si_shift[`SAH_CH_W-2:0], db_now[`SAH_SI_BIT]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sh_busy <= 1'b0;
      sh_cnt <= `SAH_BIT_ZERO;
      sh_reg <= `SAH_SAR_CLEAR;
      so_bit <= 1'b0;
    end else if (mode_par || (mode1 && !cs_low) || (mode2 && cs_low)) begin
      sh_busy <= 1'b0;
    end else if (shift_fall) begin
      if (!sh_busy && out_valid) begin
        sh_busy <= 1'b1;
        sh_cnt <= `SAH_CNT_ONE;
        so_bit <= lsb_first ? out_word[0] : out_word[`SAH_RES_W-1];
        sh_reg <= lsb_first ? (out_word >> 1) : (out_word << 1);
      end else if (sh_busy && sh_cnt == `SAH_SHIFT_LEN) begin
        sh_busy <= 1'b0;
      end else if (sh_busy) begin
        sh_cnt <= sh_cnt + 4'h1;
        so_bit <= lsb_first ? sh_reg[0] : sh_reg[`SAH_RES_W-1];
        sh_reg <= lsb_first ? (sh_reg >> 1) : (sh_reg << 1);
      end
    end
  end

  // ************************************************************
  // Bus and serial pin drivers
  // ************************************************************
  logic [`SAH_DB_W-1:0] next_db_out;
  logic [`SAH_DB_W-1:0] next_db_oe;

  always_comb begin
    next_db_out = `SAH_BUS_ZERO;
    next_db_oe = `SAH_BUS_ZERO;
    if (par_rd) begin
      next_db_oe = `SAH_BUS_ALL;
      if (sync2[`SAH_S_RS]) begin
        next_db_out = out_word[`SAH_RES_W-1 -: `SAH_DB_W];
      end else begin
        next_db_out = {out_word[1:0], `SAH_LOW_PAD};
      end
    end else if (mode1) begin
      next_db_out[`SAH_SO_BIT] = so_bit;
      next_db_oe[`SAH_SO_BIT] = cs_low;
    end else if (mode2) begin
      next_db_out[`SAH_SO_BIT] = so_bit;
      next_db_oe[`SAH_SO_BIT] = sh_busy;
      next_db_out[`SAH_SERIAL_CLOCK_OUT_BIT] = int_clk;
      next_db_oe[`SAH_SERIAL_CLOCK_OUT_BIT] = 1'b1;
      next_db_out[`SAH_SERIAL_OUT_VALID_N_BIT] = !sh_busy;
      next_db_oe[`SAH_SERIAL_OUT_VALID_N_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_bus_out <= `SAH_BUS_ZERO;
      data_bus_oe <= `SAH_BUS_ZERO;
    end else begin
      data_bus_out <= next_db_out;
      data_bus_oe <= next_db_oe;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_last_step;
    conv_state == SAH_RUN && int_rise && settled && bit_idx == `SAH_BIT_ZERO && !seq_clear;
  endsequence

  sequence s_shift_start;
    shift_fall && !sh_busy && out_valid && mode2 && !cs_low;
  endsequence

  a_chan_write: assert property (addr_wr && !(mode2 && cs_low) |=> chan == $past(db_prev[2:0]))
    else $error("channel not latched by address write");
  a_init_write: assert property (init_wr |=> fmt_cfg == $past(db_prev[2]) && div_cfg == $past(db_prev[1:0]))
    else $error("initialize write not stored");
  a_high_byte: assert property (par_rd && sync2[`SAH_S_RS] |=> data_bus_oe == `SAH_BUS_ALL
      && data_bus_out == $past(out_word[9:2]))
    else $error("high byte read wrong");
  a_low_byte: assert property (par_rd && !sync2[`SAH_S_RS] |=> data_bus_out == {$past(out_word[1:0]), `SAH_LOW_PAD})
    else $error("low byte read wrong");
  a_sar_finish: assert property (s_last_step |=> conv_state == SAH_PUSH)
    else $error("conversion did not finish after ten steps");
  a_sar_start: assert property (conv_state == SAH_IDLE && start && !seq_clear |=> conv_state == SAH_RUN
      && dac_level == `SAH_SAR_START)
    else $error("conversion start level wrong");
  a_mode2_hold: assert property (mode2 && cs_low |=> conv_state == SAH_IDLE && chan == `SAH_CH_SP)
    else $error("mode 2 chip select low did not hold reset");
  a_serial_clock_out_copy: assert property (mode2 |=> data_bus_out[`SAH_SERIAL_CLOCK_OUT_BIT] == $past(int_clk)
      && data_bus_oe[`SAH_SERIAL_CLOCK_OUT_BIT])
    else $error("serial clock out not a copy of internal clock");
  a_serial_out_valid_n_low: assert property (s_shift_start |=> sh_busy ##1 !data_bus_out[`SAH_SERIAL_OUT_VALID_N_BIT] || !mode2)
    else $error("output valid not low while shifting");
  a_mode1_float: assert property (mode1 && !cs_low |=> !data_bus_oe[`SAH_SO_BIT])
    else $error("serial output driven while deselected");
  a_so_on_fall: assert property (!mode_par && $changed(so_bit) |-> $past(shift_fall))
    else $error("serial output changed away from a falling edge");
  a_done_level: assert property ($rose(out_valid) |-> !conversion_done_n ##1 (!conversion_done_n || consume))
    else $error("done not signalled");
endmodule : sah_adc_ctrl

/* sah_analog_model.sv */
// Analog source model: eight fixed input levels and an ideal comparator.
`timescale 1ns/1ps
`include "sah_defs.svh"

module sah_analog_model
  import sah_pkg::*;
(
  // Converter side
  input wire logic [`SAH_CH_W-1:0] analog_input_mux,
  input wire logic [`SAH_RES_W-1:0] dac_level,
  output logic comparator_high
);
  // ****
  // Input levels
  // ****
  sah_word_t level [8];

  // Extremes and alternating patterns catch a search that stops one bit short.
  initial begin
    level = '{10'h000, 10'h155, 10'h2aa, 10'h3ff, 10'h001, 10'h200, 10'h1ff, 10'h0f3};
  end

  // An ideal comparator, so a correct search lands exactly on the level.
  assign comparator_high = (level[analog_input_mux] >= dac_level);
endmodule : sah_analog_model

/* sah_defs.svh */
// Constants for the converter control and host interface block.
`ifndef SAH_DEFS_SVH
`define SAH_DEFS_SVH

// ************************************************************
// Widths and depths
// ************************************************************
`define SAH_RES_W 10
`define SAH_CH_W 3
`define SAH_DB_W 8
`define SAH_FIFO_DEPTH 4
`define SAH_SYNC_W 15

// ************************************************************
// Reset and start values
// ************************************************************
`define SAH_SAR_START 10'h200
`define SAH_SAR_CLEAR 10'h000
`define SAH_LAST_BIT 4'h9
`define SAH_BIT_ZERO 4'h0
`define SAH_SHIFT_LEN 4'ha
`define SAH_CNT_ONE 4'h1
`define SAH_CH_INIT 3'h0
`define SAH_CH_SP 3'h7
`define SAH_DIV_RESET 2'h0
`define SAH_DIV_CNT_ZERO 3'h0
`define SAH_LOW_PAD 6'h00
`define SAH_BUS_ZERO 8'h00
`define SAH_BUS_ALL 8'hff
`define SAH_SYNC_IDLE 15'h0007

// ************************************************************
// Data bus bit positions
// ************************************************************
`define SAH_FMT_BIT 2
`define SAH_DIV_HI 1
`define SAH_DIV_LO 0
`define SAH_SO_BIT 7
`define SAH_SI_BIT 6
`define SAH_ORDER_BIT 5
`define SAH_SERIAL_CLOCK_OUT_BIT 4
`define SAH_SERIAL_OUT_VALID_N_BIT 3

// ************************************************************
// Positions in the synchronised input vector
// ************************************************************
`define SAH_S_CS 0
`define SAH_S_WR 1
`define SAH_S_RD 2
`define SAH_S_RS 3
`define SAH_S_MC 4
`define SAH_S_CK 5
`define SAH_S_CMP 6
`define SAH_S_DB 7

`endif

/* sah_fifo.sv */
// Small flip-flop FIFO between the converter and the result port.
`timescale 1ns/1ps
`include "sah_defs.svh"

module sah_fifo #(
  parameter int WIDTH = `SAH_RES_W,
  parameter int DEPTH = `SAH_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Pointers carry one extra wrap bit so full and empty are told apart.
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + (AW+1)'(1);
    end
  end
endmodule : sah_fifo

/* sah_pkg.sv */
// Types shared by the converter control block.
`include "sah_defs.svh"

package sah_pkg;
  typedef enum logic [1:0] {
    SAH_IDLE = 2'b00,
    SAH_RUN = 2'b01,
    SAH_PUSH = 2'b11
  } sah_conv_e;

  typedef logic [`SAH_RES_W-1:0] sah_word_t;
endpackage : sah_pkg

/* tb_sah_adc_ctrl.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`include "sah_defs.svh"

module tb_sah_adc_ctrl
  import sah_pkg::*;
;
  logic clk_sys, rst, ext_clock, interface_mode_pin, chip_select_n;
  logic write_strobe_n, read_strobe_n, register_select, conversion_done_n, comparator_high;
  logic [7:0] data_bus_in, data_bus_out, data_bus_oe, rb, ro;
  logic [2:0] analog_input_mux;
  sah_word_t dac_level;
  int fail_count, checked, cycles, t;
  int tk [4];

  sah_adc_ctrl i_sah_adc_ctrl (.clk_sys, .rst, .interface_mode_pin, .chip_select_n, .write_strobe_n,
    .read_strobe_n, .register_select, .ext_clock, .data_bus_in, .data_bus_out, .data_bus_oe,
    .conversion_done_n, .analog_input_mux, .dac_level, .comparator_high);
  sah_analog_model i_sah_analog_model (.analog_input_mux, .dac_level, .comparator_high);

  // ****
  // Clocks and watchdog
  // ****
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Device clock far below the system clock, as the synchronisers need.
  initial begin
    ext_clock = 1'b0;
    forever #48 ext_clock = ~ext_clock;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      final_report;
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic final_report;
    $display("Counts: checked=%0d failed=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : check

  function automatic sah_word_t lv(input int c);
    return i_sah_analog_model.level[c];
  endfunction : lv

  // Strobes stay low and apart for four cycles so the synchronisers see them.
  task automatic bus_cycle(input logic rs, input logic wr, input logic [7:0] val);
    @(negedge clk_sys);
    chip_select_n = 1'b0;
    register_select = rs;
    if (wr) data_bus_in = val;
    @(negedge clk_sys);
    if (wr) write_strobe_n = 1'b0;
    else read_strobe_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    rb = data_bus_out;
    ro = data_bus_oe;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chip_select_n = 1'b1;
    data_bus_in = ~data_bus_in;
    repeat (3) @(negedge clk_sys);
  endtask : bus_cycle

  task automatic run_conv(input logic [2:0] ch, input sah_word_t exp, output int n);
    bus_cycle(1'b0, 1'b1, {5'h00, ch});
    check(16'(analog_input_mux), 16'(ch));
    n = 0;
    while (conversion_done_n !== 1'b0 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    check(16'(conversion_done_n), 16'h0);
    bus_cycle(1'b1, 1'b0, 8'h00);
    check({ro, rb}, {8'hff, exp[9:2]});
    bus_cycle(1'b0, 1'b0, 8'h00);
    check({ro, rb}, {8'hff, exp[1:0], 6'h00});
    check(16'(conversion_done_n), 16'h1);
  endtask : run_conv

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    check(16'({data_bus_oe, conversion_done_n, analog_input_mux}), 16'h0008);
  endtask : t_reset

  task automatic t_channels;
    bus_cycle(1'b1, 1'b1, 8'h00);
    for (int c = 0; c < 8; c++) begin
      run_conv(3'(c), lv(c), t);
    end
  endtask : t_channels

  task automatic t_twos;
    bus_cycle(1'b1, 1'b1, 8'h04);
    run_conv(3'h3, lv(3) ^ 10'h200, t);
    run_conv(3'h0, lv(0) ^ 10'h200, t);
  endtask : t_twos

  task automatic t_refused;
    @(negedge clk_sys);
    register_select = 1'b0;
    data_bus_in = 8'h06;
    write_strobe_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    write_strobe_n = 1'b1;
    chip_select_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    write_strobe_n = 1'b0;
    read_strobe_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    check(16'(data_bus_oe), 16'h0);
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chip_select_n = 1'b1;
    repeat (200) @(negedge clk_sys);
    check(16'({analog_input_mux, conversion_done_n}), 16'h1);
  endtask : t_refused

  task automatic t_divide;
    for (int k = 0; k < 4; k++) begin
      bus_cycle(1'b1, 1'b1, 8'(k));
      run_conv(3'h1, lv(1), tk[k]);
      if (k > 0) check(16'(tk[k] > tk[k-1] + tk[k-1] / 2), 16'h1);
    end
  endtask : t_divide

  // Device-clocked serial mode: channel 7 forced, bits taken at clock rises.
  task automatic t_serial2(input logic order, input logic fmt);
    sah_word_t word;
    logic prev;
    int n, w, t0;
    interface_mode_pin = 1'b0;
    register_select = 1'b1;
    data_bus_in = {2'b01, order, 2'b00, fmt, 2'b00};
    repeat (4) @(negedge clk_sys);
    chip_select_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    check(16'(analog_input_mux), 16'h7);
    chip_select_n = 1'b1;
    n = 0;
    w = 0;
    t0 = 0;
    prev = 1'b0;
    word = '0;
    while (n < 10 && w < 4000) begin
      @(negedge clk_sys);
      w++;
      if (data_bus_out[4] === 1'b1 && !prev && data_bus_out[3] === 1'b0 && data_bus_oe[7] === 1'b1) begin
        if (n == 0) t0 = w;
        word = order ? {data_bus_out[7], word[9:1]} : {word[8:0], data_bus_out[7]};
        n++;
      end
      prev = data_bus_out[4];
    end
    check(16'(word), 16'(lv(7) ^ {fmt, 9'h000}));
    check(16'(w - t0), 16'd108);
    check(16'(data_bus_oe[4]), 16'h1);
    repeat (40) @(negedge clk_sys);
    check(16'(data_bus_out[3]), 16'h1);
  endtask : t_serial2

  // One host shift clock pulse; the serial output is taken just before the rising edge.
  task automatic sck_pulse(input logic si, output logic so);
    data_bus_in[6] = si;
    read_strobe_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    so = data_bus_out[7];
    read_strobe_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask : sck_pulse

  // Host-clocked serial mode: channel shifted in MSB first, strobe starts, result comes out MSB first.
  task automatic t_serial1(input logic [2:0] ch);
    sah_word_t word;
    logic b;
    interface_mode_pin = 1'b0;
    register_select = 1'b0;
    data_bus_in = 8'h00;
    repeat (4) @(negedge clk_sys);
    chip_select_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = 2; i >= 0; i--) sck_pulse(ch[i], b);
    write_strobe_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    write_strobe_n = 1'b1;
    repeat (300) @(negedge clk_sys);
    check(16'(analog_input_mux), 16'(ch));
    check(16'(conversion_done_n), 16'h0);
    word = '0;
    for (int i = 0; i < 11; i++) begin
      sck_pulse(1'b0, b);
      if (i < 10) word = {word[8:0], b};
    end
    check(16'(word), 16'(lv(ch)));
    check(16'({data_bus_oe[7], conversion_done_n}), 16'h3);
    chip_select_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check(16'(data_bus_oe[7]), 16'h0);
  endtask : t_serial1

  initial begin
    rst = 1'b1;
    interface_mode_pin = 1'b1;
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    register_select = 1'b0;
    data_bus_in = 8'h00;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    t_reset;
    t_channels;
    t_twos;
    t_refused;
    t_divide;
    t_serial2(1'b0, 1'b0);
    t_serial2(1'b1, 1'b1);
    t_serial1(3'h6);
    final_report;
  end
endmodule : tb_sah_adc_ctrl
